//--- src/video_digitizer_output_port.sv
// pixel output port of the triple video digitizer
// Operation
// - serial address 0x4c strap low, 0x4d high
// - buffered crystal clock, full or halved
// - word clock pixel rate, half in dual
// - second word clock always complements first
// - each colour on primary and secondary bus
// - line sync aligned, horizontal only
// - frame sync eight pixels after line end
// - buffered horizontal sync passes selected source
// - vertical sync asserted while composite sync selected and its pattern disrupted
// - phase invert swaps sampled pixel phase
`timescale 1ns/1ps
module video_digitizer_output_port
  import digitizer_out_pkg::*;
(
  // clock and reset
  input  wire logic                   i_clock,
  input  wire logic                   i_sys_rst,
  // configuration
  input  wire logic                   i_serial_address_strap,
  input  wire logic                   i_crystal_divide,
  input  wire logic                   i_output_mode,
  input  wire logic [1:0]             i_sync_select,
  input  wire logic                   i_sample_phase_invert,
  // pixel stream from the converters, one per clock
  input  wire logic [PIXEL_WIDTH-1:0] i_red,
  input  wire logic [PIXEL_WIDTH-1:0] i_green,
  input  wire logic [PIXEL_WIDTH-1:0] i_blue,
  input  wire logic                   i_line_sync,
  // raw sync pins
  input  wire logic                   i_hsync_input,
  input  wire logic                   i_sync_on_green_input,
  input  wire logic                   i_csync_input,
  // serial address
  output logic [6:0]                  o_serial_address,
  // clocks out
  output logic                        o_buffered_crystal_clock_out,
  output logic                        o_pixel_word_clock,
  output logic                        o_pixel_word_clock_n,
  // pixel buses
  output logic [PIXEL_WIDTH-1:0]      o_red_primary_bus,
  output logic [PIXEL_WIDTH-1:0]      o_red_secondary_bus,
  output logic [PIXEL_WIDTH-1:0]      o_green_primary_bus,
  output logic [PIXEL_WIDTH-1:0]      o_green_secondary_bus,
  output logic [PIXEL_WIDTH-1:0]      o_blue_primary_bus,
  output logic [PIXEL_WIDTH-1:0]      o_blue_secondary_bus,
  // syncs
  output logic                        o_line_frame_sync,
  output logic                        o_artificial_frame_sync,
  output logic                        o_buffered_horizontal_sync,
  output logic                        o_buffered_vertical_sync
);
  localparam int PW = PIXEL_WIDTH;

  logic hs_pin, sog_pin, cs_pin, inv_pin;

  sync_filter u_hs  (.i_clock(i_clock), .i_sys_rst(i_sys_rst), .i_pin(i_hsync_input),
                     .o_level(hs_pin));
  sync_filter u_sog (.i_clock(i_clock), .i_sys_rst(i_sys_rst), .i_pin(i_sync_on_green_input),
                     .o_level(sog_pin));
  sync_filter u_cs  (.i_clock(i_clock), .i_sys_rst(i_sys_rst), .i_pin(i_csync_input),
                     .o_level(cs_pin));
  sync_filter u_inv (.i_clock(i_clock), .i_sys_rst(i_sys_rst), .i_pin(i_sample_phase_invert),
                     .o_level(inv_pin));

  // state
  logic [6:0]    addr;
  logic          strap_taken;
  logic          xtal_div, xtal_out;
  logic          word_clk, phase;
  logic [3*PW-1:0] held, prim, sec;
  logic          line_sync, line_prev;
  logic          fs_pending;
  logic [3:0]    fs_count;
  logic          frame_sync;
  logic          hsync_buf, hsync_prev;
  logic [11:0]   gap_count;
  logic          vsync_buf;

  logic [6:0]    next_addr;
  logic          next_strap_taken;
  logic          next_xtal_div, next_xtal_out;
  logic          next_word_clk, next_phase;
  logic [3*PW-1:0] next_held, next_prim, next_sec;
  logic          next_line_sync, next_line_prev;
  logic          next_fs_pending;
  logic [3:0]    next_fs_count;
  logic          next_frame_sync;
  logic          next_hsync_buf, next_hsync_prev;
  logic [11:0]   next_gap_count;
  logic          next_vsync_buf;

  logic [3*PW-1:0] pixel;
  logic          sel_sync;

  assign pixel = {i_red, i_green, i_blue};

  always_comb begin
    // strap caught once after reset release
    next_strap_taken = 1'b1;
    next_addr        = addr;
    if (!strap_taken) begin
      next_addr = i_serial_address_strap ? SERIAL_ADDR_HIGH : SERIAL_ADDR_LOW;
    end
    // crystal clock stand-in: full rate toggles each clock, halved each second
    next_xtal_div = ~xtal_div;
    next_xtal_out = (i_crystal_divide ? xtal_div : 1'b1) ? ~xtal_out : xtal_out;
    // pixel pairing; invert swaps which clock starts a pair
    next_phase    = ~phase;
    next_held     = held;
    next_prim     = prim;
    next_sec      = sec;
    next_word_clk = word_clk;
    if (i_output_mode == MODE_SINGLE) begin
      next_prim     = pixel;
      next_sec      = pixel;
      next_word_clk = ~word_clk;
    end else if ((phase ^ inv_pin) == 1'b0) begin
      next_held     = pixel;
    end else begin
      // word clock toggles once per word, so dual runs at half the single rate
      next_prim     = held;
      next_sec      = pixel;
      next_word_clk = ~word_clk;
    end
    // line framing aligned with data, horizontal only
    next_line_sync = i_line_sync;
    next_line_prev = line_sync;
    next_fs_pending = fs_pending;
    next_fs_count   = fs_count;
    next_frame_sync = 1'b0;
    if (line_prev && !line_sync) begin
      next_fs_pending = 1'b1;
      next_fs_count   = 4'h1;
    end else if (fs_pending) begin
      // the fall is seen in the clock it shows on line_sync, but frame_sync is registered, so fire one count early
      if (fs_count == FRAME_SYNC_DELAY - 4'h1) begin
        next_fs_pending = 1'b0;
        next_frame_sync = 1'b1;
      end else begin
        next_fs_count = fs_count + 4'h1;
      end
    end
    // buffered horizontal sync from selected source
    unique case (i_sync_select)
      SYNC_SEL_SOG:   sel_sync = sog_pin;
      SYNC_SEL_CSYNC: sel_sync = cs_pin;
      default:        sel_sync = hs_pin;
    endcase
    next_hsync_buf  = sel_sync;
    next_hsync_prev = hsync_buf;
    // vertical: no rising horizontal edge for too long means disrupted pattern
    next_gap_count = (hsync_buf && !hsync_prev) ? 12'h0 :
                     (gap_count == VSYNC_GAP_CYCLES) ? gap_count : gap_count + 12'h1;
    next_vsync_buf = (i_sync_select == SYNC_SEL_CSYNC) &&
                     (gap_count == VSYNC_GAP_CYCLES);
  end

  always_ff @(posedge i_clock or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      addr        <= 7'h00;
      strap_taken <= 1'b0;
      xtal_div    <= 1'b0;
      xtal_out    <= 1'b0;
      word_clk    <= 1'b0;
      phase       <= 1'b0;
      held        <= '0;
      prim        <= '0;
      sec         <= '0;
      line_sync   <= 1'b0;
      line_prev   <= 1'b0;
      fs_pending  <= 1'b0;
      fs_count    <= 4'h0;
      frame_sync  <= 1'b0;
      hsync_buf   <= 1'b0;
      hsync_prev  <= 1'b0;
      gap_count   <= 12'h0;
      vsync_buf   <= 1'b0;
    end else begin
      addr        <= next_addr;
      strap_taken <= next_strap_taken;
      xtal_div    <= next_xtal_div;
      xtal_out    <= next_xtal_out;
      word_clk    <= next_word_clk;
      phase       <= next_phase;
      held        <= next_held;
      prim        <= next_prim;
      sec         <= next_sec;
      line_sync   <= next_line_sync;
      line_prev   <= next_line_prev;
      fs_pending  <= next_fs_pending;
      fs_count    <= next_fs_count;
      frame_sync  <= next_frame_sync;
      hsync_buf   <= next_hsync_buf;
      hsync_prev  <= next_hsync_prev;
      gap_count   <= next_gap_count;
      vsync_buf   <= next_vsync_buf;
    end
  end

  assign o_serial_address             = addr;
  assign o_buffered_crystal_clock_out = xtal_out;
  assign o_pixel_word_clock           = word_clk;
  assign o_pixel_word_clock_n         = ~word_clk;
  assign o_red_primary_bus            = prim[3*PW-1:2*PW];
  assign o_green_primary_bus          = prim[2*PW-1:PW];
  assign o_blue_primary_bus           = prim[PW-1:0];
  assign o_red_secondary_bus          = sec[3*PW-1:2*PW];
  assign o_green_secondary_bus        = sec[2*PW-1:PW];
  assign o_blue_secondary_bus         = sec[PW-1:0];
  assign o_line_frame_sync            = line_sync;
  assign o_artificial_frame_sync      = frame_sync;
  assign o_buffered_horizontal_sync   = hsync_buf;
  assign o_buffered_vertical_sync     = vsync_buf;

  // checks
  default clocking cb @(posedge i_clock); endclocking
  // checks start one clock after release, once every register has left reset
  default disable iff (i_sys_rst || !strap_taken);

  a_addr_strap: assert property (strap_taken |->
    addr == ($past(i_serial_address_strap, 1) ? SERIAL_ADDR_HIGH : SERIAL_ADDR_LOW)
    or $stable(addr)) else $error("serial address wrong");
  a_addr_legal: assert property (strap_taken |->
    (addr == SERIAL_ADDR_LOW || addr == SERIAL_ADDR_HIGH)) else $error("address illegal");
  a_xtal_full: assert property (!i_crystal_divide |=> xtal_out != $past(xtal_out))
    else $error("crystal clock stalled");
  a_word_single: assert property (i_output_mode == MODE_SINGLE |=> $changed(word_clk))
    else $error("word clock not at pixel rate");
  a_word_inverse: assert property (o_pixel_word_clock_n == ~o_pixel_word_clock)
    else $error("inverse clock mismatch");
  a_single_copy: assert property (i_output_mode == MODE_SINGLE |=> prim == $past(pixel))
    else $error("primary bus not current pixel");
  a_line_align: assert property (##1 line_sync == $past(i_line_sync))
    else $error("line sync misaligned");
  a_frame_delay: assert property ($fell(line_sync) |-> ##8 frame_sync)
    else $error("frame sync not eight clocks late");
  a_hsync_pass: assert property (i_sync_select == SYNC_SEL_CSYNC |=>
    hsync_buf == $past(cs_pin)) else $error("composite not passed");
  a_vsync_gap: assert property (vsync_buf |-> $past(gap_count) == VSYNC_GAP_CYCLES)
    else $error("vertical sync without disruption");
  a_dual_pair: assert property (i_output_mode == MODE_DUAL && $rose(word_clk) &&
    $past(i_output_mode) == MODE_DUAL |-> sec == $past(pixel))
    else $error("secondary not later pixel");
  a_phase_inv: assert property (i_output_mode == MODE_DUAL && $stable(inv_pin) &&
    $past(i_output_mode) == MODE_DUAL |=>
    $changed(word_clk) == ($past(phase) ^ $past(inv_pin)))
    else $error("pair phase wrong");

  c_dual:  cover property (i_output_mode == MODE_DUAL ##1 $rose(word_clk));
  c_frame: cover property (frame_sync);
  c_vsync: cover property ($rose(vsync_buf));
endmodule // video_digitizer_output_port

//--- include/digitizer_out_pkg.sv
// constants for the digitizer output port
package digitizer_out_pkg;
  localparam int          CLOCK_MHZ          = 125;
  localparam int          RESET_MIN_NS       = 1000;
  localparam int          RESET_MIN_CYCLES   = (RESET_MIN_NS * CLOCK_MHZ + 999) / 1000;
  localparam logic [6:0]  SERIAL_ADDR_LOW    = 7'h4c;
  localparam logic [6:0]  SERIAL_ADDR_HIGH   = 7'h4d;
  localparam logic [3:0]  FRAME_SYNC_DELAY   = 4'h8;
  localparam int          PIXEL_WIDTH        = 8;
  localparam logic        MODE_SINGLE        = 1'b0;
  localparam logic        MODE_DUAL          = 1'b1;
  localparam logic [1:0]  SYNC_SEL_HSYNC     = 2'h0;
  localparam logic [1:0]  SYNC_SEL_SOG       = 2'h1;
  localparam logic [1:0]  SYNC_SEL_CSYNC     = 2'h2;
  localparam logic [11:0] VSYNC_GAP_CYCLES   = 12'h400;
endpackage

//--- src/sync_filter.sv
// three-stage pin synchroniser with agreement filter
`timescale 1ns/1ps
module sync_filter (
  // clock and reset
  input  wire logic i_clock,
  input  wire logic i_sys_rst,
  // pin and filtered level
  input  wire logic i_pin,
  output logic      o_level
);
  logic [2:0] stage;
  logic       level;
  logic [2:0] next_stage;
  logic       next_level;

  always_comb begin
    next_stage = {stage[1:0], i_pin};
    next_level = (stage[2] == stage[1]) ? stage[1] : level;
  end

  always_ff @(posedge i_clock or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      stage <= 3'h0;
      level <= 1'b0;
    end else begin
      stage <= next_stage;
      level <= next_level;
    end
  end

  assign o_level = level;
endmodule // sync_filter

//--- tb/scaler_capture_model.sv
// model of the display scaler counting word clocks and frames
`timescale 1ns/1ps
module scaler_capture_model (
  // clock and reset
  input  wire logic i_clock,
  input  wire logic i_sys_rst,
  // from the digitizer
  input  wire logic i_pixel_word_clock,
  input  wire logic i_buffered_vertical_sync,
  // counts seen
  output int        o_word_rises,
  output int        o_frames
);
  logic last_wc;
  logic last_vs;
  always_ff @(posedge i_clock or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      last_wc      <= 1'b0;
      last_vs      <= 1'b0;
      o_word_rises <= 0;
      o_frames     <= 0;
    end else begin
      last_wc <= i_pixel_word_clock;
      last_vs <= i_buffered_vertical_sync;
      if (i_pixel_word_clock && !last_wc) o_word_rises <= o_word_rises + 1;
      // frame start is taken from vertical sync only
      if (i_buffered_vertical_sync && !last_vs) o_frames <= o_frames + 1;
    end
  end
endmodule // scaler_capture_model

//--- tb/test_video_digitizer_output_port.sv
// self-checking bench for the digitizer output port
`timescale 1ns/1ps
module test_video_digitizer_output_port;
  import digitizer_out_pkg::*;
  logic i_clock = 1'b0, i_sys_rst = 1'b1, i_serial_address_strap = 1'b0;
  logic i_crystal_divide = 1'b0, i_output_mode = 1'b0, i_sample_phase_invert = 1'b0;
  logic i_line_sync = 1'b0, i_hsync_input = 1'b0, i_sync_on_green_input = 1'b0;
  logic i_csync_input = 1'b0;
  logic [1:0] i_sync_select = 2'h0;
  logic [7:0] i_red = 8'h00, i_green = 8'h00, i_blue = 8'h00;
  logic [6:0] o_serial_address;
  logic o_buffered_crystal_clock_out, o_pixel_word_clock, o_pixel_word_clock_n;
  logic [7:0] o_red_primary_bus, o_red_secondary_bus, o_green_primary_bus;
  logic [7:0] o_green_secondary_bus, o_blue_primary_bus, o_blue_secondary_bus;
  logic o_line_frame_sync, o_artificial_frame_sync;
  logic o_buffered_horizontal_sync, o_buffered_vertical_sync;
  int num_errors = 0, n_compared = 0, rises, frames;
  video_digitizer_output_port video_digitizer_output_port_inst (.i_clock, .i_sys_rst,
    .i_serial_address_strap, .i_crystal_divide, .i_output_mode, .i_sync_select,
    .i_sample_phase_invert, .i_red, .i_green, .i_blue, .i_line_sync, .i_hsync_input,
    .i_sync_on_green_input, .i_csync_input, .o_serial_address, .o_buffered_crystal_clock_out,
    .o_pixel_word_clock, .o_pixel_word_clock_n, .o_red_primary_bus, .o_red_secondary_bus,
    .o_green_primary_bus, .o_green_secondary_bus, .o_blue_primary_bus, .o_blue_secondary_bus,
    .o_line_frame_sync, .o_artificial_frame_sync, .o_buffered_horizontal_sync,
    .o_buffered_vertical_sync);
  scaler_capture_model scaler_capture_model_inst (.i_clock, .i_sys_rst,
    .i_pixel_word_clock(o_pixel_word_clock),
    .i_buffered_vertical_sync(o_buffered_vertical_sync), .o_word_rises(rises),
    .o_frames(frames));
  always #4 i_clock = ~i_clock;
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      num_errors++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic finish_test;
    $display("compared %0d mismatches %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic do_reset(input logic strap, input int hold);
    @(posedge i_clock);
    i_sys_rst <= 1'b1;
    i_serial_address_strap <= strap;
    repeat (hold) @(posedge i_clock);
    chk("word clock n in reset", 32'h1, 32'(o_pixel_word_clock_n));
    i_sys_rst <= 1'b0;
    repeat (3) @(negedge i_clock);
    chk("serial address", strap ? 32'h4d : 32'h4c, 32'(o_serial_address));
    $display("reset strap %0d done", strap);
  endtask
  // single/dual streams with line sync running; 6 warm-up cycles per stream
  task automatic stream(input logic mode, input logic div);
    logic [23:0] held, p, s;
    logic [23:0] hist[$];
    logic wc, xc, lf;
    int xt, r0, cnt, k;
    cnt = 100;
    xt = 0;
    @(posedge i_clock);
    i_output_mode <= mode;
    i_crystal_divide <= div;
    i_sample_phase_invert <= mode & div;
    for (k = 0; k < 46; k++) begin
      held = {i_red, i_green, i_blue};
      wc = o_pixel_word_clock;
      xc = o_buffered_crystal_clock_out;
      lf = o_line_frame_sync;
      if (k == 6) r0 = rises;
      @(posedge i_clock);
      {i_red, i_green, i_blue} <= 24'($urandom);
      i_line_sync <= (k % 23) < 14;
      @(negedge i_clock);
      hist.push_front(held);
      p = {o_red_primary_bus, o_green_primary_bus, o_blue_primary_bus};
      s = {o_red_secondary_bus, o_green_secondary_bus, o_blue_secondary_bus};
      cnt = (lf && !o_line_frame_sync) ? 0 : cnt + 1;
      if (k >= 6) begin
        chk("word clock n", 32'(!o_pixel_word_clock), 32'(o_pixel_word_clock_n));
        chk("line frame sync", 32'(((k - 1) % 23) < 14), 32'(o_line_frame_sync));
        chk("artificial frame sync", 32'(cnt == 8), 32'(o_artificial_frame_sync));
        if (xc != o_buffered_crystal_clock_out) xt++;
        if (!mode) chk("primary bus", 32'(held), 32'(p));
        if (!mode) chk("word clock toggle", 32'(!wc), 32'(o_pixel_word_clock));
        if (mode && !wc && o_pixel_word_clock) chk("dual pair", 32'h1,
          32'((p == hist[1] && s == hist[0]) || (p == hist[2] && s == hist[1])));
      end
    end
    chk("crystal toggles", div ? 32'd20 : 32'd40, 32'(xt));
    chk("word clock rises", mode ? 32'd10 : 32'd20, 32'(rises - r0));
    $display("stream mode %0d divide %0d done", mode, div);
  endtask
  logic ls_prev = 1'b0;
  always @(posedge i_clock) ls_prev <= i_line_sync;
  always @(negedge i_clock) begin
    if (!i_sys_rst && $time > 400) chk("line sync delay", 32'(ls_prev), 32'(o_line_frame_sync));
  end
  initial begin
    #400000;
    num_errors++;
    finish_test;
  end
  initial begin
    logic [2:0] pins;
    int f0;
    void'($urandom(19149));
    repeat (10) @(posedge i_clock);
    i_sys_rst <= 1'b0;
    do_reset(1'b1, RESET_MIN_CYCLES);
    do_reset(1'b0, RESET_MIN_CYCLES);
    for (int t = 0; t < 4; t++) stream(t[1], t[0]);
    for (int sel = 0; sel < 16; sel++) begin
      pins = 3'($urandom);
      @(posedge i_clock);
      i_sync_select <= 2'(sel);
      {i_hsync_input, i_sync_on_green_input, i_csync_input} <= pins;
      repeat (8) @(negedge i_clock);
      chk("buffered hsync", 32'(sel % 4 == 1 ? pins[1] : sel % 4 == 2 ? pins[0] : pins[2]),
        32'(o_buffered_horizontal_sync));
    end
    $display("sync select done");
    f0 = frames;
    @(posedge i_clock);
    i_sync_select <= SYNC_SEL_CSYNC;
    i_csync_input <= 1'b1;
    repeat (8) @(posedge i_clock);
    i_csync_input <= 1'b0;
    repeat (20) @(negedge i_clock);
    chk("vsync before gap", 32'h0, 32'(o_buffered_vertical_sync));
    repeat (1100) @(negedge i_clock);
    chk("vsync in gap", 32'h1, 32'(o_buffered_vertical_sync));
    @(posedge i_clock);
    i_csync_input <= 1'b1;
    repeat (12) @(negedge i_clock);
    chk("vsync after gap", 32'h0, 32'(o_buffered_vertical_sync));
    chk("frames seen", 32'h1, 32'(frames - f0));
    $display("vertical sync done");
    finish_test;
  end
endmodule // test_video_digitizer_output_port
